// file: rtl/gdrv_ctl.sv
// Purpose: controller driving an isolated gate driver through its pins
// Assumes: all pin inputs synchronous to clk_i; fault line already pulled up
// Notes: produces in+/in- and the enable/clear pin, recovers from latched faults,
//   and converts the sensed-duty pwm back into a voltage code
`timescale 1ns/1ns
`include "gdrv_ctl_defines.svh"
// Operation
// - controller sends clear pulse after fault (manual mode only; in auto reset it sends none and relies on the pwm off-time)
// - clear pulse held low past filter time
// - auto reset ties in+ to enable
// - inverting auto reset needs inverted pwm
// - pwm off-time exceeds clear filter time
module gdrv_ctl
#(
  parameter int unsigned MUTE_CYC = `FAULT_MUTE_CYC,
  parameter int unsigned FILTER_CYC = `CLEAR_FILTER_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // user side
  input wire logic drive_req_i,
  input wire logic enable_req_i,
  input wire logic auto_reset_i,
  input wire logic invert_mode_i,
  input wire logic peer_on_i,
  output logic fault_seen_o,
  output logic recovering_o,
  output logic [6:0] sense_duty_o,
  output logic [15:0] sense_mv_o,
  output logic sense_valid_o,
  // driver pins
  output logic in_pos_o,
  output logic in_neg_o,
  output logic enable_clear_o,
  output logic enable_clear_oe_o,
  input wire logic fault_alarm_n_i,
  input wire logic sensed_duty_output_i
);
  typedef struct packed
  {
    gdrv_ctl_pkg::recov_e st;
    logic [`CNT_W-1:0] cnt;
    logic [`CNT_W-1:0] hold;
    logic in_pos;
    logic in_neg;
    logic en;
    logic fault;
    logic [15:0] mv;
    logic [6:0] duty;
    logic valid;
  } ctl_s;
  ctl_s s_r;
  ctl_s s_nxt;
  logic [6:0] duty_w;
  logic duty_valid_w;
  logic want_pos;
  logic want_neg;
  logic want_en;
  logic [6:0] duty_cl;

  // sensed-duty pin decoded to percent
  duty_meter u_meter
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .duty_pin_i(sensed_duty_output_i),
    .duty_pct_o(duty_w),
    .duty_valid_o(duty_valid_w)
  );

  // requested pin levels before the minimum-width guard
  always_comb
  begin
    // interlock: never ask for in+ while the peer leg is on
    want_pos = drive_req_i && !peer_on_i;
    // in- carries the peer pwm so the device interlock also guards it
    want_neg = peer_on_i;
    if (auto_reset_i)
    begin
      // enable follows the pwm; inverted when the device is driven on in-
      want_en = invert_mode_i ? !want_neg : want_pos;
    end
    else
    begin
      want_en = enable_req_i;
    end
  end

  // recovery sequencer, pin hold timer and sense conversion
  always_comb
  begin
    s_nxt = s_r;
    duty_cl = duty_w;
    if (s_r.hold != '0)
    begin
      s_nxt.hold = s_r.hold - `CNT_W'(1);
    end
    case (s_r.st)
      gdrv_ctl_pkg::st_run:
      begin
        // pins only change once the last level stood long enough, except in+ dropping on a fault
        if (s_r.hold == '0)
        begin
          if (want_pos != s_r.in_pos || want_neg != s_r.in_neg || want_en != s_r.en)
          begin
            s_nxt.hold = `CNT_W'(`DEGLITCH_CYC);
          end
          s_nxt.in_pos = want_pos;
          s_nxt.in_neg = want_neg;
          s_nxt.en = want_en;
        end
        if (!fault_alarm_n_i)
        begin
          // latched fault reported: stop driving; in manual mode wait out the mute time
          s_nxt.fault = 1'b1;
          s_nxt.in_pos = 1'b0;
          s_nxt.cnt = `CNT_W'(MUTE_CYC);
          if (!auto_reset_i)
          begin
            s_nxt.st = gdrv_ctl_pkg::st_mute;
          end
        end
        else
        begin
          s_nxt.fault = 1'b0;
        end
      end
      gdrv_ctl_pkg::st_mute:
      begin
        // clear would be ignored here, so it is not sent yet
        s_nxt.en = 1'b1;
        s_nxt.in_pos = 1'b0;
        if (s_r.cnt == '0)
        begin
          s_nxt.st = gdrv_ctl_pkg::st_clear;
          s_nxt.cnt = `CNT_W'(FILTER_CYC);
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - `CNT_W'(1);
        end
      end
      gdrv_ctl_pkg::st_clear:
      begin
        // low pulse one cycle beyond the filter time for margin
        s_nxt.en = 1'b0;
        if (s_r.cnt == '0)
        begin
          s_nxt.st = gdrv_ctl_pkg::st_release;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - `CNT_W'(1);
        end
      end
      default:
      begin
        // release: back to run once the alarm line recovered
        s_nxt.en = 1'b1;
        if (fault_alarm_n_i)
        begin
          s_nxt.st = gdrv_ctl_pkg::st_run;
          s_nxt.fault = 1'b0;
          s_nxt.hold = `CNT_W'(`DEGLITCH_CYC);
        end
        else
        begin
          // clear did not take; mute again and retry
          s_nxt.st = gdrv_ctl_pkg::st_mute;
          s_nxt.cnt = `CNT_W'(MUTE_CYC);
        end
      end
    endcase
    // auto reset relies on off-time longer than the filter; nothing to sequence
    // duty to millivolts: v = (100 - d) / 20 volts = (100 - d) * 50 mV
    if (duty_cl < 7'(`DUTY_MIN_PCT))
    begin
      duty_cl = 7'(`DUTY_MIN_PCT);
    end
    else if (duty_cl > 7'(`DUTY_MAX_PCT))
    begin
      duty_cl = 7'(`DUTY_MAX_PCT);
    end
    s_nxt.valid = duty_valid_w;
    if (duty_valid_w)
    begin
      s_nxt.duty = duty_cl;
      s_nxt.mv = 16'((7'd100 - duty_cl) * 16'd50);
    end
  end

  // state register; enable pin driven low at reset, matching the pulldown
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign in_pos_o = s_r.in_pos;
  assign in_neg_o = s_r.in_neg;
  assign enable_clear_o = s_r.en;
  // the pin is always actively driven from the controller side
  assign enable_clear_oe_o = 1'b1;
  assign fault_seen_o = s_r.fault;
  assign recovering_o = s_r.st != gdrv_ctl_pkg::st_run;
  assign sense_duty_o = s_r.duty;
  assign sense_mv_o = s_r.mv;
  assign sense_valid_o = s_r.valid;

  // never both drive inputs high from this side
  chk_no_both_high: assert property (@(posedge clk_i) disable iff (reset_i)
    !(in_pos_o && in_neg_o))
    else $error("in+ and in- both high");
  // no clear pulse during the mute interval
  chk_mute_no_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    s_r.st == gdrv_ctl_pkg::st_mute |=> enable_clear_o || s_r.st != gdrv_ctl_pkg::st_mute)
    else $error("clear sent during mute");
  // the pin drops one cycle after entering clear, then stays low on every counted
  // filter cycle; a counter bound keeps this cheap whatever the filter length
  chk_clear_width: assert property (@(posedge clk_i) disable iff (reset_i)
    s_r.st == gdrv_ctl_pkg::st_clear && s_r.cnt != `CNT_W'(FILTER_CYC)
    |-> !enable_clear_o)
    else $error("clear pulse too short");
  // fault alarm stops in+ next cycle
  chk_fault_stops: assert property (@(posedge clk_i) disable iff (reset_i)
    !fault_alarm_n_i |=> !in_pos_o)
    else $error("in+ kept high after fault");
  // manual fault enters the mute state
  chk_fault_mute: assert property (@(posedge clk_i) disable iff (reset_i)
    s_r.st == gdrv_ctl_pkg::st_run && !fault_alarm_n_i && !auto_reset_i
    |=> s_r.st == gdrv_ctl_pkg::st_mute)
    else $error("fault did not start recovery");
  // mute ends in clear within 300 cycles
  chk_mute_len: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(s_r.st == gdrv_ctl_pkg::st_mute) |-> ##[1:300] s_r.st == gdrv_ctl_pkg::st_clear)
    else $error("mute did not end");
  // an in+ rise holds for the deglitch width
  chk_pin_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    s_r.st == gdrv_ctl_pkg::st_run && $changed(in_pos_o) && !$fell(in_pos_o)
    |=> $stable(in_pos_o) || !fault_alarm_n_i)
    else $error("in+ pulse below deglitch width");
  // sense value stays in the documented voltage range
  chk_sense_range: assert property (@(posedge clk_i) disable iff (reset_i)
    sense_valid_o |-> sense_mv_o >= 16'h0258 && sense_mv_o <= 16'h1194)
    else $error("sense voltage out of range");
  // auto mode: enable follows in+
  chk_auto_en: assert property (@(posedge clk_i) disable iff (reset_i)
    s_r.st == gdrv_ctl_pkg::st_run && auto_reset_i && !invert_mode_i
    && fault_alarm_n_i |-> enable_clear_o == in_pos_o)
    else $error("auto enable mismatch");

  cov_fault_recover: cover property (@(posedge clk_i) disable iff (reset_i)
    s_r.st == gdrv_ctl_pkg::st_release ##1 s_r.st == gdrv_ctl_pkg::st_run);
  cov_drive: cover property (@(posedge clk_i) disable iff (reset_i) $rose(in_pos_o));
  cov_sense: cover property (@(posedge clk_i) disable iff (reset_i) sense_valid_o);
  cov_auto: cover property (@(posedge clk_i) disable iff (reset_i)
    auto_reset_i && !fault_alarm_n_i);
endmodule

// file: rtl/gdrv_ctl_defines.svh
// Purpose: constants for the gate-driver host controller
// Assumes: 10 MHz clock (100 ns period)
// Notes: times kept in their own unit, cycle counts derived from them
`ifndef GDRV_CTL_DEFINES_SVH
`define GDRV_CTL_DEFINES_SVH
`define CLK_PERIOD_NS 100
// fault mute time and clear filter time, as seen by the controller
`define FAULT_MUTE_NS 2000
`define CLEAR_FILTER_NS 1000
// least times round up to whole cycles
`define FAULT_MUTE_CYC ((`FAULT_MUTE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLEAR_FILTER_CYC ((`CLEAR_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// device deglitch: pulses below this are rejected, so every level is held longer
`define DEGLITCH_NS 40
`define DEGLITCH_CYC ((`DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// sensed-duty carrier 400 kHz, period 2500 ns
`define SENSE_PERIOD_NS 2500
`define SENSE_PERIOD_CYC (`SENSE_PERIOD_NS / `CLK_PERIOD_NS)
// duty figures in percent
`define DUTY_MIN_PCT 10
`define DUTY_MAX_PCT 88
`define CNT_W 8
`endif

// file: rtl/gdrv_ctl_pkg.sv
// Purpose: types for the gate-driver host controller
// Assumes: nothing beyond the defines header
// Notes: gray-coded recovery states
package gdrv_ctl_pkg;
  typedef enum logic [1:0]
  {
    st_run = 2'b00,
    st_mute = 2'b01,
    st_clear = 2'b11,
    st_release = 2'b10
  } recov_e;
endpackage

// file: rtl/duty_meter.sv
// Purpose: measures high time and period of the sensed-duty pin
// Assumes: pin synchronous to clk_i
// Notes: result is duty in percent, updated once per carrier period
`timescale 1ns/1ns
`include "gdrv_ctl_defines.svh"
module duty_meter
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // sensed pwm pin
  input wire logic duty_pin_i,
  // result
  output logic [6:0] duty_pct_o,
  output logic duty_valid_o
);
  typedef struct packed
  {
    logic prev;
    logic [7:0] high_cnt;
    logic [7:0] per_cnt;
    logic [6:0] duty;
    logic valid;
  } meter_s;
  meter_s s_r;
  meter_s s_nxt;
  logic [15:0] scaled;

  // a rising edge closes one period; duty = 100 * high / period
  always_comb
  begin
    s_nxt = s_r;
    scaled = 16'h0000;
    s_nxt.prev = duty_pin_i;
    s_nxt.valid = 1'b0;
    if (duty_pin_i && !s_r.prev && s_r.per_cnt != 8'h00)
    begin
      // period measured rather than assumed, so a drifting carrier still scales right
      scaled = 16'((s_r.high_cnt * 16'd100) / s_r.per_cnt);
      s_nxt.duty = scaled[6:0];
      s_nxt.valid = 1'b1;
      s_nxt.per_cnt = 8'h01;
      s_nxt.high_cnt = 8'h01;
    end
    else
    begin
      // saturate so a stuck pin cannot wrap the counters
      if (s_r.per_cnt != 8'hff)
      begin
        s_nxt.per_cnt = s_r.per_cnt + 8'h01;
      end
      if (duty_pin_i && s_r.high_cnt != 8'hff)
      begin
        s_nxt.high_cnt = s_r.high_cnt + 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign duty_pct_o = s_r.duty;
  assign duty_valid_o = s_r.valid;
endmodule

// file: verification/drv_model.sv
// Purpose: behavioural model of the isolated gate driver, seen from its input pins
// Assumes: pins sampled on clk_i; one 100 ns cycle is longer than the deglitch span
// Notes: fault latch with mute and clear filter, interlock, sensed-duty carrier
`timescale 1ns/1ns
`include "gdrv_ctl_defines.svh"
module drv_model
#(
  parameter int unsigned MUTE_CYC = 4,
  parameter int unsigned FILTER_CYC = 3
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // host pins
  input wire logic in_pos_i,
  input wire logic in_neg_i,
  input wire logic enable_pin_i,
  output logic fault_alarm_n_o,
  output logic sensed_duty_output_o,
  // bench side
  input wire logic saturation_sense_i,
  input wire logic [6:0] duty_i,
  output logic gate_on_o,
  output logic soft_off_o
);
  logic fault_r; // latched saturation fault
  int unsigned mute_r; // cycles since the fault
  int unsigned low_r; // enable-low cycles counted after mute
  int unsigned car_r; // carrier phase
  // gate on only when enabled, unfaulted and in+ alone
  assign gate_on_o = enable_pin_i && !fault_r && in_pos_i && !in_neg_i;
  assign fault_alarm_n_o = !fault_r;
  assign soft_off_o = fault_r;
  // high time scales with duty; carrier period fixed
  assign sensed_duty_output_o = car_r < (duty_i * `SENSE_PERIOD_CYC / 100);
  // carrier counter, independent of the sensed value
  always_ff @(posedge clk_i)
  begin
    car_r <= (reset_i || car_r == `SENSE_PERIOD_CYC - 1) ? 0 : car_r + 1;
  end
  // pins seen only at edges, so shorter glitches never reach the latch
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      fault_r <= 1'b0;
      mute_r <= 0;
      low_r <= 0;
    end
    else if (saturation_sense_i && !fault_r)
    begin
      fault_r <= 1'b1;
      mute_r <= 0;
      low_r <= 0;
    end
    else if (fault_r)
    begin
      // clear pin ignored while muted
      if (mute_r < MUTE_CYC)
        mute_r <= mute_r + 1;
      else if (enable_pin_i)
        low_r <= 0;
      else if (low_r + 1 >= FILTER_CYC)
        fault_r <= 1'b0;
      else
        low_r <= low_r + 1;
    end
  end
endmodule

// file: verification/gdrv_ctl_tb.sv
// Purpose: self-checking bench for the gate-driver host controller
// Assumes: shortened mute and filter counts so recovery runs quickly
// Notes: inputs change on falling edges, outputs are read there too
`timescale 1ns/1ns
`include "gdrv_ctl_defines.svh"
module gdrv_ctl_tb;
  localparam int unsigned MUTE = 4; // shortened mute count
  localparam int unsigned FILT = 3; // shortened filter count
  localparam logic [15:0] MV_TAB [3] = '{16'h1130, 16'h0960, 16'h0258}; // sensed mV
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic drive_req, enable_req, auto_reset, invert_mode, peer_on, sat;
  logic [6:0] duty_in; // duty the model puts on its carrier
  logic fault_seen_o, recovering_o, sense_valid_o, in_pos_o, in_neg_o;
  logic enable_clear_o, enable_clear_oe_o, alarm_n, duty_pin, gate_on, soft_off;
  logic [6:0] sense_duty_o;
  logic [15:0] sense_mv_o;
  wire en_pin;
  int unsigned n_errors = 0;
  int unsigned checks = 0;
  // undriven pin falls to the pulldown level
  assign en_pin = enable_clear_oe_o ? enable_clear_o : 1'b0;
  always #50 clk_i = ~clk_i;
  gdrv_ctl #(.MUTE_CYC(MUTE), .FILTER_CYC(FILT)) u_gdrv_ctl (.clk_i(clk_i),
    .reset_i(reset_i), .drive_req_i(drive_req), .enable_req_i(enable_req),
    .auto_reset_i(auto_reset), .invert_mode_i(invert_mode), .peer_on_i(peer_on),
    .fault_seen_o(fault_seen_o), .recovering_o(recovering_o), .sense_duty_o(sense_duty_o),
    .sense_mv_o(sense_mv_o), .sense_valid_o(sense_valid_o), .in_pos_o(in_pos_o),
    .in_neg_o(in_neg_o), .enable_clear_o(enable_clear_o),
    .enable_clear_oe_o(enable_clear_oe_o), .fault_alarm_n_i(alarm_n),
    .sensed_duty_output_i(duty_pin));
  drv_model #(.MUTE_CYC(MUTE), .FILTER_CYC(FILT)) u_drv_model (.clk_i(clk_i),
    .reset_i(reset_i), .in_pos_i(in_pos_o), .in_neg_i(in_neg_o), .enable_pin_i(en_pin),
    .fault_alarm_n_o(alarm_n), .sensed_duty_output_o(duty_pin),
    .saturation_sense_i(sat), .duty_i(duty_in), .gate_on_o(gate_on), .soft_off_o(soft_off));
  // compare with four-state equality, count and report
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int unsigned n);
    repeat (n) @(negedge clk_i);
  endtask
  // one-cycle saturation pulse, then let the latch show
  task automatic sat_pulse;
    sat = 1'b1;
    cyc(1);
    sat = 1'b0;
    cyc(2);
  endtask
  task automatic end_sim;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // plain drive, interlock and disable
  task automatic t_drive;
    chk("rst_en", 0, en_pin);
    enable_req = 1'b1;
    drive_req = 1'b1;
    cyc(4);
    chk("gate", 1, gate_on);
    peer_on = 1'b1;
    cyc(4);
    chk("lock_pos", 0, in_pos_o);
    chk("lock_neg", 1, in_neg_o);
    chk("lock_gate", 0, gate_on);
    peer_on = 1'b0;
    enable_req = 1'b0;
    cyc(4);
    chk("dis_gate", 0, gate_on);
    enable_req = 1'b1;
    cyc(4);
  endtask
  // latched fault and timed clear pulse
  task automatic t_fault;
    int unsigned n = 0;
    int unsigned m = 0;
    sat_pulse();
    chk("alarm", 0, alarm_n);
    chk("seen", 1, fault_seen_o);
    chk("soft", 1, soft_off);
    while (en_pin === 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    // detection and two alarm cycles already went by inside sat_pulse
    chk("mute", 16'(MUTE + 1), 16'(n));
    while (en_pin === 1'b0 && m < 200)
    begin
      cyc(1);
      m++;
    end
    chk("filter", 16'(FILT + 1), 16'(m));
    n = 0;
    while (recovering_o !== 1'b0 && n < 200)
    begin
      cyc(1);
      n++;
    end
    // a recovery that never ends counts as a mismatch
    chk("recov_end", 1, 16'(n < 200));
    cyc(3);
    chk("clr_seen", 0, fault_seen_o);
    chk("clr_gate", 1, gate_on);
  endtask
  // per-cycle reset, then enable following the pwm in both polarities
  task automatic t_auto;
    auto_reset = 1'b1;
    enable_req = 1'b0;
    cyc(4);
    chk("auto_en", 1, en_pin);
    sat_pulse();
    chk("auto_alarm", 0, alarm_n);
    drive_req = 1'b0;
    cyc(MUTE + FILT + 4);
    chk("auto_clr", 1, alarm_n);
    // enable is low here, so the high phase proves the inversion first
    invert_mode = 1'b1;
    cyc(4);
    chk("inv_hi", 1, enable_clear_o);
    peer_on = 1'b1;
    cyc(4);
    chk("inv_lo", 0, enable_clear_o);
    peer_on = 1'b0;
    auto_reset = 1'b0;
    invert_mode = 1'b0;
  endtask
  task automatic wait_valid(output int unsigned c);
    c = 0;
    do
    begin
      cyc(1);
      c++;
    end
    while (sense_valid_o !== 1'b1 && c < 200);
  endtask
  // carrier duty back to voltage, low to high end
  task automatic t_sense;
    int unsigned c;
    for (int i = 0; i < 3; i++)
    begin
      duty_in = 7'(100 - MV_TAB[i] / 50);
      wait_valid(c);
      wait_valid(c);
      wait_valid(c);
      chk("period", 16'(`SENSE_PERIOD_CYC), 16'(c));
      chk("duty", 16'(duty_in), 16'(sense_duty_o));
      chk("mv", MV_TAB[i], sense_mv_o);
    end
    // carrier duty outside the span at either end is held at the span limits
    for (int j = 0; j < 2; j++)
    begin
      duty_in = j ? 7'h60 : 7'h04;
      repeat (3) wait_valid(c);
      chk("clamp", j ? 16'(`DUTY_MAX_PCT) : 16'(`DUTY_MIN_PCT), 16'(sense_duty_o));
      chk("clamp_mv", j ? MV_TAB[2] : 16'h1194, sense_mv_o);
    end
  endtask
  initial
  begin
    {drive_req, enable_req, auto_reset, invert_mode, peer_on, sat} = 6'h00;
    duty_in = 7'h34;
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    cyc(1);
    t_drive();
    t_fault();
    t_auto();
    t_sense();
    end_sim();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #(20000 * 100);
    n_errors++;
    end_sim();
  end
endmodule
